// file: bfs_assertions.sv
// checker: timing properties of the supervisor seen at its ports
`timescale 1ns/1ns
module bfs_checker #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_block_input,
    input wire logic i_external_initiate,
    input wire logic o_pready,
    input wire logic o_internal_pickup,
    input wire logic o_external_pickup,
    input wire logic o_failure_trip,
    input wire logic o_internal_failure_trip,
    input wire logic o_external_failure_trip,
    input wire logic o_retrip_routing,
    input wire logic o_state_off,
    input wire logic o_state_blocked,
    input wire logic o_state_active
);
    // shortest delay is 6 ticks; first tick may come after one cycle
    localparam int MIN_RUN = 5 * TICK_CYCLES;
    int ext_run;
    // ---------------------------------------------
    // cycles the external pickup has stood unbroken
    // ---------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst || !o_external_pickup) begin
            ext_run <= 0;
        end else begin
            ext_run <= ext_run + 1;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    state_onehot_a: assert property ($onehot({o_state_off, o_state_blocked, o_state_active}))
        else $error("state flags not one-hot");
    trip_or_a: assert property (o_failure_trip == (o_internal_failure_trip | o_external_failure_trip))
        else $error("general trip differs from source trips");
    int_trip_cause_a: assert property ($rose(o_internal_failure_trip) |-> $past(o_internal_pickup))
        else $error("internal trip without pickup");
    ext_delay_a: assert property ($rose(o_external_failure_trip) |-> ext_run >= MIN_RUN)
        else $error("external trip before the delay");
    ext_held_a: assert property (!i_external_initiate [*3] |-> !o_external_pickup)
        else $error("external pickup without held initiate");
    block_clear_a: assert property (i_block_input [*5] |-> !o_state_active && !o_failure_trip
        && !o_internal_pickup && !o_external_pickup)
        else $error("blocked but outputs still set");
    off_inert_a: assert property (o_state_off [*4] |-> !o_internal_pickup && !o_external_pickup)
        else $error("pickup while switched off");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready stood longer than one cycle");
    retrip_idle_a: assert property (!(o_internal_pickup || o_external_pickup) [*2]
        |-> !o_retrip_routing)
        else $error("retrip without pickup");
endmodule
bind bfs_breaker_fail_protect bfs_checker #(.TICK_CYCLES(TICK_CYCLES)) u_bfs_checker (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_block_input(i_block_input),
    .i_external_initiate(i_external_initiate), .o_pready(o_pready),
    .o_internal_pickup(o_internal_pickup), .o_external_pickup(o_external_pickup),
    .o_failure_trip(o_failure_trip), .o_internal_failure_trip(o_internal_failure_trip),
    .o_external_failure_trip(o_external_failure_trip), .o_retrip_routing(o_retrip_routing),
    .o_state_off(o_state_off), .o_state_blocked(o_state_blocked),
    .o_state_active(o_state_active)
);

// file: bfs_breaker_fail_protect.sv
// breaker failure supervisor with apb register slave and interrupt
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
module bfs_breaker_fail_protect #(
    parameter int TICK_CYCLES = bfs_pkg::TICK_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_config_enable,
    input wire logic i_block_input,
    input wire logic i_failure_initiate,
    input wire logic i_external_initiate,
    input wire logic [11:0] i_phase_a,
    input wire logic [11:0] i_phase_b,
    input wire logic [11:0] i_phase_c,
    input wire logic i_aux_no,
    input wire logic i_aux_nc,
    output logic o_internal_pickup,
    output logic o_external_pickup,
    output logic o_failure_trip,
    output logic o_internal_failure_trip,
    output logic o_external_failure_trip,
    output logic o_retrip_routing,
    output logic o_state_off,
    output logic o_state_blocked,
    output logic o_state_active,
    output logic o_irq
);
    // ------------------------------------------------------------
    // configuration strap, caught one edge after reset release
    // ------------------------------------------------------------
    logic rst_d_r;
    logic cfg_en_r;
    always_ff @(posedge i_mclk) begin
        rst_d_r <= i_rst;
        if (i_rst) begin
            cfg_en_r <= 1'b0;
        end else if (rst_d_r) begin
            cfg_en_r <= i_config_enable;
        end
    end

    // ------------------------------------------------------------
    // registers and apb decode
    // ------------------------------------------------------------
    bfs_pkg::bfs_ctrl_t ctrl_r;
    logic [12:0] delay_r;
    logic [11:0] thresh_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic [2:0] irq_event;
    logic [31:0] status_word;
    logic [31:0] rd_data;
    logic rd_hit;

    wire access = i_psel && i_penable && !o_pready;
    // a write lands on the edge that completes the transfer, pready seen high
    wire wr = i_psel && i_penable && o_pready && i_pwrite;
    wire sel_ctrl = i_paddr == bfs_pkg::ADDR_CTRL;
    wire sel_delay = i_paddr == bfs_pkg::ADDR_DELAY;
    wire sel_thresh = i_paddr == bfs_pkg::ADDR_THRESH;
    wire sel_status = i_paddr == bfs_pkg::ADDR_STATUS;
    wire sel_istat = i_paddr == bfs_pkg::ADDR_IRQ_STAT;
    wire sel_imask = i_paddr == bfs_pkg::ADDR_IRQ_MASK;
    // out-of-range delays are clamped so the tick count stays in range
    wire [12:0] wr_delay = i_pwdata[12:0];
    wire [12:0] delay_nxt = (wr_delay < bfs_pkg::DELAY_MIN) ? bfs_pkg::DELAY_MIN :
        (wr_delay > bfs_pkg::DELAY_MAX) ? bfs_pkg::DELAY_MAX : wr_delay;

    // read mux as an if chain, unmapped addresses answer with an error
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        if (sel_ctrl) begin
            rd_data = {26'h0, ctrl_r};
        end else if (sel_delay) begin
            rd_data = {19'h0, delay_r};
        end else if (sel_thresh) begin
            rd_data = {20'h0, thresh_r};
        end else if (sel_status) begin
            rd_data = status_word;
        end else if (sel_istat) begin
            rd_data = {29'h0, irq_stat_r};
        end else if (sel_imask) begin
            rd_data = {29'h0, irq_mask_r};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // one wait state: pready rises the cycle after the access phase starts
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_pready <= access;
            o_pslverr <= access && !rd_hit;
            o_prdata <= (access && !i_pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // settings written by software
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_r <= bfs_pkg::bfs_ctrl_t'(bfs_pkg::CTRL_RESET);
            delay_r <= bfs_pkg::DELAY_RESET;
            thresh_r <= bfs_pkg::THRESH_RESET;
            irq_mask_r <= bfs_pkg::IRQ_MASK_RESET;
        end else begin
            if (wr && sel_ctrl) begin
                ctrl_r <= bfs_pkg::bfs_ctrl_t'(i_pwdata[5:0]);
            end
            if (wr && sel_delay) begin
                delay_r <= delay_nxt;
            end
            if (wr && sel_thresh) begin
                thresh_r <= i_pwdata[11:0];
            end
            if (wr && sel_imask) begin
                irq_mask_r <= i_pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // operating state
    // ------------------------------------------------------------
    bfs_pkg::bfs_state_t state;
    assign state = (!cfg_en_r || !ctrl_r.function_switch) ? bfs_pkg::BFS_OFF :
        i_block_input ? bfs_pkg::BFS_BLOCKED : bfs_pkg::BFS_ACTIVE;
    wire active = state == bfs_pkg::BFS_ACTIVE;

    // ------------------------------------------------------------
    // breaker position, tracked at all times
    // ------------------------------------------------------------
    logic [11:0] phase [3];
    logic [2:0] phase_over;
    assign phase[0] = i_phase_a;
    assign phase[1] = i_phase_b;
    assign phase[2] = i_phase_c;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            assign phase_over[g] = phase[g] > thresh_r;
        end
    endgenerate
    wire current_flow = |phase_over;

    // contact inputs are high while the contact is closed; no contact is
    // closed with the breaker closed, nc contact is open with it closed
    function automatic logic aux_closed(input bfs_pkg::bfs_aux_t mode,
                                        input logic no_c, input logic nc_c);
        case (mode)
            bfs_pkg::BFS_AUX_BOTH: aux_closed = no_c && !nc_c;
            bfs_pkg::BFS_AUX_NO_ONLY: aux_closed = no_c;
            bfs_pkg::BFS_AUX_NC_ONLY: aux_closed = !nc_c;
            default: aux_closed = 1'b0; // no contact: never claims closed
        endcase
    endfunction

    // an auxiliary contact may open before the arc clears, so current
    // flow alone keeps the criterion alive even if contacts say open
    logic brk_closed_r;
    wire brk_closed_nxt = current_flow ||
        (ctrl_r.contact_check_select &&
         aux_closed(ctrl_r.aux_wiring, i_aux_no, i_aux_nc));
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            brk_closed_r <= 1'b0;
        end else begin
            brk_closed_r <= brk_closed_nxt;
        end
    end

    // ------------------------------------------------------------
    // time base shared by both delay timers
    // ------------------------------------------------------------
    logic [16:0] pre_r;
    wire tick = pre_r == 17'(TICK_CYCLES - 1);
    always_ff @(posedge i_mclk) begin
        if (i_rst || tick) begin
            pre_r <= 17'h00000;
        end else begin
            pre_r <= pre_r + 17'h00001;
        end
    end

    // ------------------------------------------------------------
    // two independent initiation paths: 0 internal, 1 external
    // ------------------------------------------------------------
    logic [1:0] pick_r;
    logic [1:0] trip_r;
    logic [12:0] cnt_r [2];
    logic [1:0] pick_nxt;
    // internal initiation is latched while the breaker still looks closed,
    // external must stay present for the whole delay against bounce
    assign pick_nxt[0] = active && brk_closed_r &&
        (pick_r[0] || i_failure_initiate);
    assign pick_nxt[1] = active && brk_closed_r && i_external_initiate;
    generate
        for (g = 0; g < 2; g++) begin : g_path
            always_ff @(posedge i_mclk) begin
                if (i_rst || !pick_nxt[g]) begin
                    pick_r[g] <= 1'b0;
                    trip_r[g] <= 1'b0;
                    cnt_r[g] <= 13'h0000;
                end else begin
                    pick_r[g] <= 1'b1;
                    if (pick_r[g] && tick && cnt_r[g] != delay_r) begin
                        cnt_r[g] <= cnt_r[g] + 13'h0001;
                    end
                    trip_r[g] <= pick_r[g] && cnt_r[g] == delay_r;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt: sticky status, write one to clear, set wins
    // ------------------------------------------------------------
    logic trip_any_d_r;
    logic [1:0] pick_d_r;
    assign irq_event[bfs_pkg::IRQ_INT_PICKUP] = pick_r[0] && !pick_d_r[0];
    assign irq_event[bfs_pkg::IRQ_EXT_PICKUP] = pick_r[1] && !pick_d_r[1];
    assign irq_event[bfs_pkg::IRQ_TRIP] = (|trip_r) && !trip_any_d_r;
    wire [2:0] irq_clr = (wr && sel_istat) ? i_pwdata[2:0] : 3'h0;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            irq_stat_r <= 3'h0;
            pick_d_r <= 2'h0;
            trip_any_d_r <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_event;
            pick_d_r <= pick_r;
            trip_any_d_r <= |trip_r;
            o_irq <= |(((irq_stat_r & ~irq_clr) | irq_event) & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_internal_pickup <= 1'b0;
            o_external_pickup <= 1'b0;
            o_failure_trip <= 1'b0;
            o_internal_failure_trip <= 1'b0;
            o_external_failure_trip <= 1'b0;
            o_retrip_routing <= 1'b0;
            o_state_off <= 1'b1;
            o_state_blocked <= 1'b0;
            o_state_active <= 1'b0;
        end else begin
            o_internal_pickup <= pick_r[0];
            o_external_pickup <= pick_r[1];
            o_failure_trip <= |trip_r;
            o_internal_failure_trip <= trip_r[0];
            o_external_failure_trip <= trip_r[1];
            o_retrip_routing <= (ctrl_r.retrip_int && pick_r[0]) ||
                (ctrl_r.retrip_ext && pick_r[1]);
            o_state_off <= state == bfs_pkg::BFS_OFF;
            o_state_blocked <= state == bfs_pkg::BFS_BLOCKED;
            o_state_active <= active;
        end
    end

    assign status_word = {23'h0, brk_closed_r, trip_r, pick_r, 1'b0,
                          o_state_active, o_state_blocked, o_state_off};
endmodule

// file: bfs_breaker_fail_protect_tb.sv
// testbench: scenario tasks for the breaker failure supervisor
`timescale 1ns/1ns
module bfs_breaker_fail_protect_tb;
    localparam int TK = 10;
    logic i_mclk, i_rst, i_psel, i_penable, i_pwrite, i_config_enable, er;
    logic i_block_input, i_failure_initiate, i_external_initiate, closed;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [11:0] i_phase_a, i_phase_b, i_phase_c, amps;
    logic [1:0] sel;
    logic i_aux_no, i_aux_nc, o_pready, o_pslverr, o_irq, o_retrip_routing;
    logic o_internal_pickup, o_external_pickup, o_failure_trip;
    logic o_internal_failure_trip, o_external_failure_trip;
    logic o_state_off, o_state_blocked, o_state_active;
    int num_errors, comparisons, cyc;
    bfs_breaker_fail_protect #(.TICK_CYCLES(TK)) u_bfs_breaker_fail_protect (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_config_enable(i_config_enable),
        .i_block_input(i_block_input), .i_failure_initiate(i_failure_initiate),
        .i_external_initiate(i_external_initiate), .i_phase_a(i_phase_a),
        .i_phase_b(i_phase_b), .i_phase_c(i_phase_c), .i_aux_no(i_aux_no),
        .i_aux_nc(i_aux_nc), .o_internal_pickup(o_internal_pickup),
        .o_external_pickup(o_external_pickup), .o_failure_trip(o_failure_trip),
        .o_internal_failure_trip(o_internal_failure_trip),
        .o_external_failure_trip(o_external_failure_trip),
        .o_retrip_routing(o_retrip_routing), .o_state_off(o_state_off),
        .o_state_blocked(o_state_blocked), .o_state_active(o_state_active), .o_irq(o_irq)
    );
    bfs_breaker_model u_bfs_breaker_model (
        .i_closed(closed), .i_phase_sel(sel), .i_amps(amps), .o_phase_a(i_phase_a),
        .o_phase_b(i_phase_b), .o_phase_c(i_phase_c), .o_aux_no(i_aux_no), .o_aux_nc(i_aux_nc)
    );
    initial begin
        i_mclk = 0;
        forever #50 i_mclk = ~i_mclk;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    // one apb transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        // only the hang guard ends a wait that never sees pready
        do @(posedge i_mclk); while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", e, rd);
    endtask
    task automatic reset_dut(input logic strap);
        i_config_enable <= strap;
        i_rst <= 1'b1;
        w(4);
        i_rst <= 1'b0;
        w(3);
    endtask
    task automatic pulse_int();
        i_failure_initiate <= 1'b1;
        w(1);
        i_failure_initiate <= 1'b0;
    endtask
    // strap low: reset values, unmapped access, function stays inert
    task automatic t_regs();
        reset_dut(1'b0);
        chk("off", 1, o_state_off);
        rdc(bfs_pkg::ADDR_CTRL, 32'h0);
        rdc(bfs_pkg::ADDR_DELAY, 32'h19);
        rdc(bfs_pkg::ADDR_THRESH, 32'h10);
        rdc(bfs_pkg::ADDR_IRQ_MASK, 32'h0);
        rdc(8'h18, 32'h0);
        chk("slverr", 1, er);
        apb(1'b1, bfs_pkg::ADDR_CTRL, 32'h1);
        closed <= 1'b1;
        i_external_initiate <= 1'b1;
        w(10);
        chk("ext pickup", 0, o_external_pickup);
        i_external_initiate <= 1'b0;
        $display("test regs done");
    endtask
    // delay clamps to its range, then the shortest delay is kept
    task automatic t_clamp();
        reset_dut(1'b1);
        apb(1'b1, bfs_pkg::ADDR_DELAY, 32'h1);
        rdc(bfs_pkg::ADDR_DELAY, 32'h6);
        apb(1'b1, bfs_pkg::ADDR_DELAY, 32'h1FFF);
        rdc(bfs_pkg::ADDR_DELAY, 32'h1770);
        apb(1'b1, bfs_pkg::ADDR_DELAY, 32'h6);
        $display("test clamp done");
    endtask
    // external initiation runs the full delay into a trip, with interrupt
    task automatic t_ext();
        apb(1'b1, bfs_pkg::ADDR_CTRL, 32'h9);
        apb(1'b1, bfs_pkg::ADDR_IRQ_MASK, 32'h7);
        chk("active", 1, o_state_active);
        i_external_initiate <= 1'b1;
        w(4);
        chk("ext pickup", 1, o_external_pickup);
        chk("retrip", 1, o_retrip_routing);
        w(40);
        chk("trip early", 0, o_failure_trip);
        w(40);
        chk("ext trip", 1, o_external_failure_trip);
        chk("trip", 1, o_failure_trip);
        chk("int trip", 0, o_internal_failure_trip);
        chk("irq", 1, o_irq);
        rdc(bfs_pkg::ADDR_IRQ_STAT, 32'h6);
        i_external_initiate <= 1'b0;
        w(4);
        chk("trip gone", 0, o_failure_trip);
        apb(1'b1, bfs_pkg::ADDR_IRQ_STAT, 32'h7);
        w(3);
        chk("irq clear", 0, o_irq);
        $display("test ext done");
    endtask
    // a one-cycle gap in the external initiate restarts the delay
    task automatic t_bounce();
        i_external_initiate <= 1'b1;
        w(40);
        i_external_initiate <= 1'b0;
        w(1);
        i_external_initiate <= 1'b1;
        w(25);
        chk("bounce trip", 0, o_failure_trip);
        chk("repickup", 1, o_external_pickup);
        i_external_initiate <= 1'b0;
        w(4);
        $display("test bounce done");
    endtask
    // internal pickup on phase c drops when the breaker opens
    task automatic t_drop();
        sel <= 2'h2;
        pulse_int();
        w(4);
        chk("int pickup", 1, o_internal_pickup);
        chk("retrip int off", 0, o_retrip_routing);
        w(20);
        closed <= 1'b0;
        w(4);
        chk("pickup drop", 0, o_internal_pickup);
        w(60);
        chk("no trip", 0, o_internal_failure_trip);
        amps <= 12'h010;
        closed <= 1'b1;
        w(2);
        pulse_int();
        w(5);
        chk("at threshold", 0, o_internal_pickup);
        // above threshold the latched internal pickup runs into a trip
        amps <= 12'h020;
        w(2);
        pulse_int();
        w(70);
        chk("int trip", 1, o_internal_failure_trip);
        chk("ext trip off", 0, o_external_failure_trip);
        rdc(bfs_pkg::ADDR_STATUS, 32'h154);
        closed <= 1'b0;
        $display("test drop done");
    endtask
    // contacts alone judge a currentless breaker, for every wiring case
    task automatic t_contact();
        amps <= 12'h000;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, bfs_pkg::ADDR_CTRL, {26'h0, m[1:0], 4'h3});
            closed <= 1'b1;
            w(3);
            pulse_int();
            w(4);
            chk("contact pickup", m != 3, o_internal_pickup);
            closed <= 1'b0;
            w(4);
        end
        apb(1'b1, bfs_pkg::ADDR_CTRL, 32'h1);
        closed <= 1'b1;
        w(3);
        pulse_int();
        w(4);
        chk("contact ignored", 0, o_internal_pickup);
        $display("test contact done");
    endtask
    // block input and function switch take the function down
    task automatic t_block();
        amps <= 12'h020;
        sel <= 2'h1;
        i_external_initiate <= 1'b1;
        w(4);
        chk("pickup", 1, o_external_pickup);
        i_block_input <= 1'b1;
        w(5);
        chk("blocked", 1, o_state_blocked);
        chk("blk pickup", 0, o_external_pickup);
        i_block_input <= 1'b0;
        i_external_initiate <= 1'b0;
        w(3);
        chk("active", 1, o_state_active);
        apb(1'b1, bfs_pkg::ADDR_CTRL, 32'h0);
        w(2);
        chk("off", 1, o_state_off);
        $display("test block done");
    endtask
    initial begin
        i_rst = 1'b1;
        {i_psel, i_penable, i_pwrite, i_config_enable, i_block_input} = 5'h00;
        {i_failure_initiate, i_external_initiate, closed} = 3'h0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0;
        amps = 12'h020;
        sel = 2'h0;
        t_regs();
        t_clamp();
        closed <= 1'b1;
        t_ext();
        t_bounce();
        t_drop();
        t_contact();
        t_block();
        stop_test();
    end
endmodule

// file: bfs_breaker_model.sv
// breaker model: phase currents and auxiliary contacts for one breaker position
`timescale 1ns/1ns
module bfs_breaker_model (
    input wire logic i_closed,
    input wire logic [1:0] i_phase_sel,
    input wire logic [11:0] i_amps,
    output logic [11:0] o_phase_a,
    output logic [11:0] o_phase_b,
    output logic [11:0] o_phase_c,
    output logic o_aux_no,
    output logic o_aux_nc
);
    // an open breaker carries nothing; one chosen phase carries the load
    wire logic [11:0] amps = i_closed ? i_amps : 12'h000;
    assign o_phase_a = (i_phase_sel == 2'h0) ? amps : 12'h000;
    assign o_phase_b = (i_phase_sel == 2'h1) ? amps : 12'h000;
    assign o_phase_c = (i_phase_sel == 2'h2) ? amps : 12'h000;
    // normally-open contact follows the breaker, normally-closed the inverse
    assign o_aux_no = i_closed;
    assign o_aux_nc = !i_closed;
endmodule

// file: bfs_pkg.sv
// package: register map, field layout, timing constants and carriers of the supervisor
// Summary of operation
// - initiation: pickup alarm, delay, then failure trip
// - internal and external paths kept fully separate
// - any phase above threshold means current flows
// - contact check on: current and contacts judged
// - contact check off: current flow only
// - criterion lost: timer drops, no trip
// - external initiate held for whole delay
// - function switch and block input disable
// - inert unless enabled at configuration
// - delay 0.06 to 60.00 s, default 0.25
// - open contact open, closed contact inverted
// - four auxiliary contact wiring cases supported
// - breaker state tracked before any initiation
// - pickup optionally routed onto retrip output
// - general trip plus source specific trip
// - status shows off, blocked or active
package bfs_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_THRESH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [12:0] DELAY_MIN = 13'h0006;
    localparam logic [12:0] DELAY_MAX = 13'h1770;
    localparam logic [12:0] DELAY_RESET = 13'h0019;
    localparam logic [11:0] THRESH_RESET = 12'h010;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam int IRQ_INT_PICKUP = 0;
    localparam int IRQ_EXT_PICKUP = 1;
    localparam int IRQ_TRIP = 2;
    // ------------------------------------------------------------
    // timing: the delay counts 10 ms ticks of a 10 MHz clock
    // ------------------------------------------------------------
    localparam int TICK_US = 10000;
    localparam int CLK_MHZ = 10;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    // auxiliary contact wiring cases
    typedef enum logic [1:0] {
        BFS_AUX_BOTH,
        BFS_AUX_NO_ONLY,
        BFS_AUX_NC_ONLY,
        BFS_AUX_NONE
    } bfs_aux_t;
    // software settings carried as one word
    typedef struct packed {
        bfs_aux_t aux_wiring;
        logic retrip_ext;
        logic retrip_int;
        logic contact_check_select;
        logic function_switch;
    } bfs_ctrl_t;
    // operating state
    typedef enum logic [1:0] {
        BFS_OFF,
        BFS_BLOCKED,
        BFS_ACTIVE
    } bfs_state_t;
endpackage
